// [cfiaf_pkg.sv]
// Shared constants, types and helpers for the core state block.
// Assumes a single 25 MHz core clock and one active-high reset.
package cfiaf_pkg;

  localparam int OFS_W   = 16;
  localparam int PHYS_W  = 20;
  localparam int QUEUE_W = 4;

  // Reset values
  localparam logic [15:0] OFS_RESET       = 16'h0000;
  localparam logic [15:0] CODE_SEG_RESET  = 16'hFFFF;
  localparam logic [15:0] OTHER_SEG_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET    = 16'hF000;

  // Status word layout
  localparam logic [15:0] STATUS_ONES = 16'hF000;
  localparam logic [15:0] STATUS_IMPL = 16'h0FD5;
  localparam int CARRY_POS  = 0;
  localparam int PARITY_POS = 2;
  localparam int NIBBLE_POS = 4;
  localparam int ZERO_POS   = 6;
  localparam int SIGN_POS   = 7;
  localparam int STEP_POS   = 8;
  localparam int IEN_POS    = 9;
  localparam int DIR_POS    = 10;
  localparam int OVF_POS    = 11;

  localparam int BYTE_MSB   = 7;
  localparam int WORD_MSB   = 15;
  localparam int NIBBLE_BIT = 4;
  localparam logic [3:0] SEG_PAD = 4'h0;

  // String pointer steps
  localparam logic [15:0] STR_BYTE_STEP = 16'h0001;
  localparam logic [15:0] STR_WORD_STEP = 16'h0002;

  // Register port addresses
  localparam logic [3:0] REG_STATUS   = 4'h0;
  localparam logic [3:0] REG_OFS      = 4'h1;
  localparam logic [3:0] REG_SEG_BASE = 4'h2;
  localparam logic [3:0] REG_SEG_LAST = 4'h5;
  localparam logic [3:0] REG_QUEUE    = 4'h6;

  typedef enum logic [1:0] {
    seg_code, seg_data, seg_stack, seg_extra
  } cfiaf_seg_type;

  typedef enum logic [1:0] {
    ref_fetch, ref_data, ref_stack, ref_string_dst
  } cfiaf_ref_type;

  typedef enum logic [3:0] {
    op_add, op_adc, op_sub, op_sbb, op_and, op_or, op_xor, op_rcl, op_rcr
  } cfiaf_alu_op_type;

  typedef enum logic [2:0] {
    cause_none, cause_soft, cause_ovf, cause_nmi, cause_step, cause_mask
  } cfiaf_cause_type;

  // Base shifted by four plus offset; carry out of bit 19 is dropped
  function automatic logic [PHYS_W-1:0] phys_addr(
    input logic [OFS_W-1:0] base,
    input logic [OFS_W-1:0] ofs
  );
    return {base, SEG_PAD} + {SEG_PAD, ofs};
  endfunction

  // Default segment for each kind of reference
  function automatic cfiaf_seg_type seg_pick(input cfiaf_ref_type r);
    unique case (r)
      ref_fetch:      return seg_code;
      ref_stack:      return seg_stack;
      ref_string_dst: return seg_extra;
      default:        return seg_data;
    endcase
  endfunction

endpackage

// [cfiaf_alu_flags.sv]
// Combinational 8/16-bit ALU with status flag generation.
// Assumes operands are stable for the cycle in which they are used.
`timescale 1ns/10ps
module cfiaf_alu_flags (
  input  wire cfiaf_pkg::cfiaf_alu_op_type op,
  input  wire logic                        word,
  input  wire logic [15:0]                 a,
  input  wire logic [15:0]                 b,
  input  wire logic                        carry_in,
  output logic      [15:0]                 result,
  output logic                             carry,
  output logic                             nibble,
  output logic                             ovf,
  output logic                             zero,
  output logic                             sign,
  output logic                             parity,
  output logic                             rotate
);

  function automatic logic msb_of(input logic [15:0] v, input logic w);
    return w ? v[cfiaf_pkg::WORD_MSB] : v[cfiaf_pkg::BYTE_MSB];
  endfunction

  logic        sub;
  logic        cin_eff;
  logic [15:0] bx;
  logic [15:0] lg;
  logic [16:0] s_w;
  logic [8:0]  s_b;

  always_comb begin
    sub     = (op == cfiaf_pkg::op_sub) || (op == cfiaf_pkg::op_sbb);
    bx      = sub ? ~b : b;
    cin_eff = sub ^ (carry_in && (op == cfiaf_pkg::op_adc ||
                                   op == cfiaf_pkg::op_sbb));
    s_w     = {1'b0, a} + {1'b0, bx} + {16'h0000, cin_eff};
    s_b     = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin_eff};
    lg      = a;
    result  = a;
    carry   = 1'b0;
    nibble  = 1'b0;
    ovf     = 1'b0;
    rotate  = 1'b0;
    unique case (op)
      cfiaf_pkg::op_add, cfiaf_pkg::op_adc,
      cfiaf_pkg::op_sub, cfiaf_pkg::op_sbb: begin
        result = word ? s_w[15:0] : {a[15:8], s_b[7:0]};
        // RULE_06 carry or borrow
        carry  = (word ? s_w[16] : s_b[8]) ^ sub;
        // RULE_05 low nibble carry
        nibble = a[cfiaf_pkg::NIBBLE_BIT] ^ b[cfiaf_pkg::NIBBLE_BIT] ^
                 result[cfiaf_pkg::NIBBLE_BIT];
        // RULE_07 signed overflow
        ovf    = (msb_of(a, word) == msb_of(bx, word)) &&
                 (msb_of(result, word) != msb_of(a, word));
      end
      cfiaf_pkg::op_and, cfiaf_pkg::op_or, cfiaf_pkg::op_xor: begin
        if (op == cfiaf_pkg::op_and) begin
          lg = a & b;
        end else if (op == cfiaf_pkg::op_or) begin
          lg = a | b;
        end else begin
          lg = a ^ b;
        end
        result = word ? lg : {a[15:8], lg[7:0]};
      end
      cfiaf_pkg::op_rcl: begin
        // RULE_06 rotate bit into carry
        rotate = 1'b1;
        result = word ? {a[14:0], carry_in} : {a[15:8], a[6:0], carry_in};
        carry  = msb_of(a, word);
        ovf    = msb_of(result, word) ^ carry;
      end
      cfiaf_pkg::op_rcr: begin
        rotate = 1'b1;
        result = word ? {carry_in, a[15:1]} : {a[15:8], carry_in, a[7:1]};
        carry  = a[0];
        ovf    = msb_of(result, word) ^
                 (word ? result[14] : result[6]);
      end
      default: begin
        result = a;
      end
    endcase
    // RULE_10 zero result
    zero   = word ? (result == 16'h0000) : (result[7:0] == 8'h00);
    // RULE_08 sign copies msb
    sign   = msb_of(result, word);
    // RULE_09 RULE_22 even parity low byte
    parity = ~^result[7:0];
  end

endmodule

// [cfiaf_core.sv]
// Core state: next-fetch offset, status word, segment bases, address
// former, string pointer stepping and interrupt acceptance.
// Assumes the execute and fetch units drive one-cycle request pulses
// synchronous to ref_clk, and software uses the plain register port.
//
// Notes on behaviour
// RULE_01 - Fetch unit keeps a 16-bit offset of the next byte to fetch.
// RULE_02 - Saved offset is corrected back to the next instruction to execute.
// RULE_03 - Reset clears the next-fetch offset to zero.
// RULE_04 - Reset sets code base to FFFF and other three bases to zero.
// RULE_05 - Nibble carry flags carry or borrow across bit 3 of low byte.
// RULE_06 - Carry flags carry or borrow at msb; rotates shift into it.
// RULE_07 - Overflow flags signed overflow; trap-on-overflow request uses it.
// RULE_08 - Sign flag copies the result msb.
// RULE_09 - Parity flag set on an even count of one bits.
// RULE_10 - Zero flag set when the whole result is zero.
// RULE_11 - Direction set decrements string pointers, clear increments them.
// RULE_12 - Interrupt enable gates maskable requests.
// RULE_13 - Software and non-maskable requests ignore interrupt enable.
// RULE_14 - Single-step raises an internal interrupt after each instruction.
// RULE_15 - All flags live in one 16-bit word, reset to F000.
// RULE_16 - Flag bits at 0,2,4,6,7,8,9,10,11; top nibble reads ones.
// RULE_17 - Memory references present a 20-bit physical address.
// RULE_18 - Bases and offsets are unsigned 16-bit; pairs may alias.
// RULE_19 - Physical address is base shifted four plus offset, carry dropped.
// RULE_20 - A segment spans at most 64K bytes from its base.
// RULE_21 - Segment base chosen by reference type unless overridden.
// RULE_22 - Parity uses only the low eight result bits.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module cfiaf_core #(
  parameter int QUEUE_W = cfiaf_pkg::QUEUE_W
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic [3:0]                    reg_addr,
  input  wire logic [15:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [15:0]                   reg_rdata,
  input  wire logic                          fetch_adv,
  input  wire logic [1:0]                    fetch_bytes,
  input  wire logic                          exec_take,
  input  wire logic [1:0]                    exec_bytes,
  input  wire logic                          ofs_load,
  input  wire logic [15:0]                   ofs_value,
  input  wire logic                          push_req,
  output logic      [15:0]                   push_ofs,
  output logic                               push_valid,
  input  wire logic                          alu_valid,
  input  wire cfiaf_pkg::cfiaf_alu_op_type   alu_op,
  input  wire logic                          alu_word,
  input  wire logic [15:0]                   alu_a,
  input  wire logic [15:0]                   alu_b,
  output logic      [15:0]                   alu_result,
  output logic                               alu_done,
  output logic      [15:0]                   status_word,
  input  wire logic                          str_step,
  input  wire logic                          str_word,
  input  wire logic [15:0]                   str_ptr_in,
  output logic      [15:0]                   str_ptr,
  input  wire logic                          sw_int_req,
  input  wire logic                          into_req,
  input  wire logic                          nmi_req,
  input  wire logic                          instr_done,
  input  wire logic                          irq_mask_req,
  output logic                               int_take,
  output cfiaf_pkg::cfiaf_cause_type         int_cause,
  input  wire logic                          mem_req,
  input  wire cfiaf_pkg::cfiaf_ref_type      mem_ref,
  input  wire logic [15:0]                   mem_ofs,
  input  wire logic                          seg_ovr_en,
  input  wire cfiaf_pkg::cfiaf_seg_type      seg_ovr_sel,
  output logic      [19:0]                   phys_addr,
  output logic                               phys_valid
);

  logic [15:0]                next_fetch_offset_r;
  logic [QUEUE_W-1:0]         queue_r;
  logic [QUEUE_W-1:0]         queue_nxt;
  logic [15:0]                exec_ofs;
  logic [15:0]                status_r;
  logic [15:0]                seg_r [4];
  logic [15:0]                alu_res;
  logic                       f_carry;
  logic                       f_nibble;
  logic                       f_ovf;
  logic                       f_zero;
  logic                       f_sign;
  logic                       f_parity;
  logic                       f_rotate;
  cfiaf_pkg::cfiaf_seg_type   sel_seg;
  logic [15:0]                sel_ofs;
  logic [15:0]                str_delta;

  cfiaf_alu_flags u_alu (
    .op       (alu_op),
    .word     (alu_word),
    .a        (alu_a),
    .b        (alu_b),
    .carry_in (status_r[cfiaf_pkg::CARRY_POS]),
    .result   (alu_res),
    .carry    (f_carry),
    .nibble   (f_nibble),
    .ovf      (f_ovf),
    .zero     (f_zero),
    .sign     (f_sign),
    .parity   (f_parity),
    .rotate   (f_rotate)
  );

  // Next-fetch offset and prefetched byte count
  // RULE_01 RULE_03 offset tracking
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      next_fetch_offset_r <= cfiaf_pkg::OFS_RESET;
    end else if (ofs_load) begin
      next_fetch_offset_r <= ofs_value;
    end else if (fetch_adv) begin
      // Wraps inside the 64K code segment
      next_fetch_offset_r <= next_fetch_offset_r + {14'h0000, fetch_bytes};
    end
  end

  always_comb begin
    queue_nxt = queue_r;
    if (fetch_adv) begin
      queue_nxt = queue_nxt + QUEUE_W'(fetch_bytes);
    end
    if (exec_take) begin
      queue_nxt = queue_nxt - QUEUE_W'(exec_bytes);
    end
  end

  // A load flushes prefetched bytes, so nothing is left to back out
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      queue_r <= '0;
    end else if (ofs_load) begin
      queue_r <= '0;
    end else begin
      queue_r <= queue_nxt;
    end
  end

  // RULE_02 back out prefetched bytes
  assign exec_ofs = next_fetch_offset_r - 16'(queue_r);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      push_ofs   <= cfiaf_pkg::OFS_RESET;
      push_valid <= 1'b0;
    end else begin
      push_valid <= push_req;
      if (push_req) begin
        push_ofs <= exec_ofs;
      end
    end
  end

  // Status word; an ALU update in the same cycle beats a software write
  // RULE_15 RULE_16 status word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_r <= cfiaf_pkg::STATUS_RESET;
    end else begin
      if (reg_wr && reg_addr == cfiaf_pkg::REG_STATUS) begin
        status_r <= (reg_wdata & cfiaf_pkg::STATUS_IMPL) |
                    cfiaf_pkg::STATUS_ONES;
      end
      if (alu_valid) begin
        status_r[cfiaf_pkg::CARRY_POS] <= f_carry;
        status_r[cfiaf_pkg::OVF_POS]   <= f_ovf;
        // Rotates leave the result flags alone
        if (!f_rotate) begin
          status_r[cfiaf_pkg::NIBBLE_POS] <= f_nibble;
          status_r[cfiaf_pkg::ZERO_POS]   <= f_zero;
          status_r[cfiaf_pkg::SIGN_POS]   <= f_sign;
          status_r[cfiaf_pkg::PARITY_POS] <= f_parity;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alu_result  <= 16'h0000;
      alu_done    <= 1'b0;
      status_word <= cfiaf_pkg::STATUS_RESET;
    end else begin
      alu_done    <= alu_valid;
      status_word <= status_r;
      if (alu_valid) begin
        alu_result <= alu_res;
      end
    end
  end

  // Segment bases, written over the register port
  // RULE_04 segment reset values
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        seg_r[i] <= cfiaf_pkg::OTHER_SEG_RESET;
      end
      seg_r[cfiaf_pkg::seg_code] <= cfiaf_pkg::CODE_SEG_RESET;
    end else if (reg_wr && reg_addr >= cfiaf_pkg::REG_SEG_BASE &&
                 reg_addr <= cfiaf_pkg::REG_SEG_LAST) begin
      seg_r[2'(reg_addr - cfiaf_pkg::REG_SEG_BASE)] <= reg_wdata;
    end
  end

  // Read data stand one cycle, unmapped reads return zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == cfiaf_pkg::REG_STATUS) begin
      reg_rdata <= status_r;
    end else if (reg_addr == cfiaf_pkg::REG_OFS) begin
      reg_rdata <= next_fetch_offset_r;
    end else if (reg_addr == cfiaf_pkg::REG_QUEUE) begin
      reg_rdata <= 16'(queue_r);
    end else if (reg_addr >= cfiaf_pkg::REG_SEG_BASE &&
                 reg_addr <= cfiaf_pkg::REG_SEG_LAST) begin
      reg_rdata <= seg_r[2'(reg_addr - cfiaf_pkg::REG_SEG_BASE)];
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Address former; fetches never take an override
  // RULE_21 segment selection
  always_comb begin
    sel_seg = cfiaf_pkg::seg_pick(mem_ref);
    sel_ofs = mem_ofs;
    if (mem_ref == cfiaf_pkg::ref_fetch) begin
      sel_ofs = next_fetch_offset_r;
    end else if (seg_ovr_en) begin
      sel_seg = seg_ovr_sel;
    end
  end

  // RULE_17 RULE_18 RULE_19 RULE_20 address former
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phys_addr  <= 20'h00000;
      phys_valid <= 1'b0;
    end else begin
      phys_valid <= mem_req;
      if (mem_req) begin
        phys_addr <= cfiaf_pkg::phys_addr(seg_r[sel_seg], sel_ofs);
      end
    end
  end

  // RULE_11 string pointer direction
  assign str_delta = str_word ? cfiaf_pkg::STR_WORD_STEP
                              : cfiaf_pkg::STR_BYTE_STEP;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      str_ptr <= 16'h0000;
    end else if (str_step) begin
      str_ptr <= status_r[cfiaf_pkg::DIR_POS] ? str_ptr_in - str_delta
                                              : str_ptr_in + str_delta;
    end
  end

  // Acceptance priority: soft, overflow trap, nmi, step, maskable
  // RULE_12 RULE_13 RULE_14 interrupt acceptance
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_take  <= 1'b0;
      int_cause <= cfiaf_pkg::cause_none;
    end else begin
      int_take  <= 1'b1;
      if (sw_int_req) begin
        int_cause <= cfiaf_pkg::cause_soft;
      end else if (into_req && status_r[cfiaf_pkg::OVF_POS]) begin
        // RULE_07 trap on overflow
        int_cause <= cfiaf_pkg::cause_ovf;
      end else if (nmi_req) begin
        int_cause <= cfiaf_pkg::cause_nmi;
      end else if (instr_done && status_r[cfiaf_pkg::STEP_POS]) begin
        int_cause <= cfiaf_pkg::cause_step;
      end else if (irq_mask_req && status_r[cfiaf_pkg::IEN_POS]) begin
        int_cause <= cfiaf_pkg::cause_mask;
      end else begin
        int_take  <= 1'b0;
        int_cause <= cfiaf_pkg::cause_none;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_ofs_reset: assert property ( // RULE_03
    $fell(rst) |-> next_fetch_offset_r == cfiaf_pkg::OFS_RESET)
    else $error("offset not zero after reset");

  chk_seg_reset: assert property ( // RULE_04
    $fell(rst) |-> seg_r[cfiaf_pkg::seg_code] == cfiaf_pkg::CODE_SEG_RESET
      && seg_r[cfiaf_pkg::seg_data] == cfiaf_pkg::OTHER_SEG_RESET)
    else $error("segment bases wrong after reset");

  chk_fetch_advance: assert property ( // RULE_01
    fetch_adv && !ofs_load |=> next_fetch_offset_r ==
      16'($past(next_fetch_offset_r) + $past(fetch_bytes)))
    else $error("offset did not advance by fetched bytes");

  chk_push_adjust: assert property ( // RULE_02
    push_req && queue_r != '0 |=> push_valid &&
      push_ofs == $past(next_fetch_offset_r) - 16'($past(queue_r)))
    else $error("saved offset not corrected");

  chk_zero_flag: assert property ( // RULE_10
    alu_valid && alu_op == cfiaf_pkg::op_sub && alu_a == alu_b |=> ##1
      status_word[cfiaf_pkg::ZERO_POS] && !status_word[cfiaf_pkg::CARRY_POS])
    else $error("zero flag wrong for equal subtract");

  chk_sign_parity: assert property ( // RULE_08
    alu_valid && alu_word && alu_op == cfiaf_pkg::op_add |=> ##1
      status_word[cfiaf_pkg::SIGN_POS] == alu_result[cfiaf_pkg::WORD_MSB]
      && status_word[cfiaf_pkg::PARITY_POS] == ~^alu_result[7:0])
    else $error("sign or parity flag mismatch");

  chk_upper_ones: assert property ( // RULE_16
    status_r[15:12] == 4'hF && status_r[1] == 1'b0)
    else $error("fixed status bits wrong");

  chk_phys_form: assert property ( // RULE_19
    mem_req && mem_ref == cfiaf_pkg::ref_data && !seg_ovr_en |=>
      phys_valid && phys_addr == 20'({$past(seg_r[cfiaf_pkg::seg_data]),
      cfiaf_pkg::SEG_PAD} + {cfiaf_pkg::SEG_PAD, $past(mem_ofs)}))
    else $error("physical address misformed");

  chk_mask_gate: assert property ( // RULE_12
    irq_mask_req && !status_r[cfiaf_pkg::IEN_POS] && !sw_int_req &&
      !nmi_req && !into_req && !instr_done |=> !int_take)
    else $error("masked request accepted");

  chk_nmi_taken: assert property ( // RULE_13
    nmi_req && !sw_int_req && !into_req |=>
      int_take && int_cause == cfiaf_pkg::cause_nmi)
    else $error("non-maskable request not taken");

  chk_step_trap: assert property ( // RULE_14
    instr_done && status_r[cfiaf_pkg::STEP_POS] && !sw_int_req &&
      !into_req && !nmi_req |=> int_cause == cfiaf_pkg::cause_step)
    else $error("single-step trap missing");

  chk_str_dir: assert property ( // RULE_11
    str_step && status_r[cfiaf_pkg::DIR_POS] |=>
      str_ptr == $past(str_ptr_in) - $past(str_delta))
    else $error("string pointer did not decrement");

  cov_push: cover property (push_req && queue_r != '0);
  cov_step: cover property (int_take && int_cause == cfiaf_pkg::cause_step);
  cov_wrap: cover property (mem_req && seg_r[sel_seg] == 16'hFFFF &&
                            sel_ofs == 16'hFFFF);
  cov_ovr:  cover property (mem_req && seg_ovr_en &&
                            mem_ref != cfiaf_pkg::ref_fetch);

endmodule

// [cfiaf_exec_model.sv]
// Execute-unit stand-in: turns a bench command into one ALU request.
// Assumes the bench raises go for exactly one ref_clk cycle.
`timescale 1ns/10ps
module cfiaf_exec_model (
  input  wire logic                        ref_clk,
  input  wire logic                        go,
  input  wire cfiaf_pkg::cfiaf_alu_op_type op_in,
  input  wire logic                        word_in,
  input  wire logic [15:0]                 a_in,
  input  wire logic [15:0]                 b_in,
  output logic                             alu_valid,
  output cfiaf_pkg::cfiaf_alu_op_type      alu_op,
  output logic                             alu_word,
  output logic [15:0]                      alu_a,
  output logic [15:0]                      alu_b
);
  initial begin
    alu_valid = 1'b0;
    alu_op = cfiaf_pkg::op_add;
    alu_word = 1'b0;
    alu_a = 16'h0000;
    alu_b = 16'h0000;
  end
  // Idle operands keep changing so a stale sample cannot pass
  always @(posedge ref_clk) begin
    alu_valid <= go;
    alu_op <= go ? op_in : alu_op;
    alu_word <= go ? word_in : ~alu_word;
    alu_a <= go ? a_in : ~alu_a;
    alu_b <= go ? b_in : ~alu_b;
  end
endmodule

// [cfiaf_core_test.sv]
// Self-checking bench for the core state block.
// Assumes the exec model drives the ALU group; all else from here.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module cfiaf_core_test;
  logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, fetch_adv = 0;
  logic exec_take = 0, ofs_load = 0, push_req = 0, go = 0, word_in = 0;
  logic str_step = 0, str_word = 0, sw_int_req = 0, into_req = 0;
  logic nmi_req = 0, instr_done = 0, irq_mask_req = 0, mem_req = 0;
  logic seg_ovr_en = 0, push_valid, alu_done, int_take, phys_valid;
  logic alu_valid, alu_word;
  logic [1:0] fetch_bytes = 0, exec_bytes = 0;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, ofs_value = 0, a_in = 0, b_in = 0;
  logic [15:0] str_ptr_in = 0, mem_ofs = 0, reg_rdata, push_ofs;
  logic [15:0] alu_a, alu_b, alu_result, status_word, str_ptr;
  logic [19:0] phys_addr;
  cfiaf_pkg::cfiaf_alu_op_type op_in = cfiaf_pkg::op_add, alu_op;
  cfiaf_pkg::cfiaf_ref_type mem_ref = cfiaf_pkg::ref_fetch;
  cfiaf_pkg::cfiaf_seg_type seg_ovr_sel = cfiaf_pkg::seg_code;
  cfiaf_pkg::cfiaf_cause_type int_cause;
  int error_cnt = 0, n_compared = 0, cyc = 0;

  cfiaf_exec_model model (.ref_clk(ref_clk), .go(go), .op_in(op_in),
    .word_in(word_in), .a_in(a_in), .b_in(b_in), .alu_valid(alu_valid),
    .alu_op(alu_op), .alu_word(alu_word), .alu_a(alu_a), .alu_b(alu_b));
  cfiaf_core dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fetch_adv(fetch_adv), .fetch_bytes(fetch_bytes),
    .exec_take(exec_take), .exec_bytes(exec_bytes), .ofs_load(ofs_load),
    .ofs_value(ofs_value), .push_req(push_req), .push_ofs(push_ofs),
    .push_valid(push_valid), .alu_valid(alu_valid), .alu_op(alu_op),
    .alu_word(alu_word), .alu_a(alu_a), .alu_b(alu_b),
    .alu_result(alu_result), .alu_done(alu_done),
    .status_word(status_word), .str_step(str_step), .str_word(str_word),
    .str_ptr_in(str_ptr_in), .str_ptr(str_ptr), .sw_int_req(sw_int_req),
    .into_req(into_req), .nmi_req(nmi_req), .instr_done(instr_done),
    .irq_mask_req(irq_mask_req), .int_take(int_take),
    .int_cause(int_cause), .mem_req(mem_req), .mem_ref(mem_ref),
    .mem_ofs(mem_ofs), .seg_ovr_en(seg_ovr_en), .seg_ovr_sel(seg_ovr_sel),
    .phys_addr(phys_addr), .phys_valid(phys_valid));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Ceiling far above the fewer than one hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [15:0] e);
    tick(); reg_rd <= 1; reg_addr <= a;
    tick(); reg_rd <= 0; #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    tick(); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    tick(); reg_wr <= 0;
  endtask
  task automatic mem_form(input cfiaf_pkg::cfiaf_ref_type r,
                          input logic [15:0] o, input logic [19:0] e);
    tick(); mem_req <= 1; mem_ref <= r; mem_ofs <= o;
    tick(); mem_req <= 0; #1;
    `CHK({phys_valid, phys_addr}, {1'b1, e})
  endtask
  task automatic alu_run(input cfiaf_pkg::cfiaf_alu_op_type op,
    input logic w, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] er, input logic [15:0] es);
    tick(); go <= 1; op_in <= op; word_in <= w; a_in <= a; b_in <= b;
    tick(); go <= 0;
    tick(); #1;
    `CHK({alu_done, alu_result}, {1'b1, er})
    tick(); #1;
    `CHK(status_word, es)
  endtask
  // Request bits: soft, overflow trap, nmi, step, maskable
  task automatic int_run(input logic [4:0] r,
                         input cfiaf_pkg::cfiaf_cause_type e);
    tick();
    {sw_int_req, into_req, nmi_req, instr_done, irq_mask_req} <= r;
    tick();
    {sw_int_req, into_req, nmi_req, instr_done, irq_mask_req} <= 5'h00;
    #1;
    `CHK({int_take, int_cause}, {e != cfiaf_pkg::cause_none, e})
  endtask
  task automatic str_run(input logic [15:0] p, input logic [15:0] e);
    tick(); str_step <= 1; str_word <= 1; str_ptr_in <= p;
    tick(); str_step <= 0; #1;
    `CHK(str_ptr, e)
  endtask

  initial begin
    repeat (12) tick();
    rst <= 0;
    reg_read(cfiaf_pkg::REG_STATUS, 16'hF000);
    reg_read(cfiaf_pkg::REG_OFS, 16'h0000);
    reg_read(cfiaf_pkg::REG_SEG_BASE, 16'hFFFF);
    reg_read(4'h3, 16'h0000);
    mem_form(cfiaf_pkg::ref_fetch, 16'h0000, 20'hFFFF0);
    reg_write(4'h3, 16'h002B);
    mem_form(cfiaf_pkg::ref_data, 16'h0013, 20'h002C3);
    reg_write(4'h3, 16'h002C);
    mem_form(cfiaf_pkg::ref_data, 16'h0003, 20'h002C3);
    reg_write(4'h4, 16'h1000);
    mem_form(cfiaf_pkg::ref_stack, 16'h0007, 20'h10007);
    tick(); ofs_load <= 1; ofs_value <= 16'h0010;
    tick(); ofs_load <= 0;
    mem_form(cfiaf_pkg::ref_fetch, 16'h1234, 20'h00000);
    tick(); fetch_adv <= 1; fetch_bytes <= 2;
    tick(); tick(); fetch_adv <= 0; exec_take <= 1; exec_bytes <= 1;
    tick(); exec_take <= 0; push_req <= 1;
    tick(); push_req <= 0; #1;
    `CHK({push_valid, push_ofs}, {1'b1, 16'h0011})
    reg_read(cfiaf_pkg::REG_OFS, 16'h0014);
    reg_read(cfiaf_pkg::REG_QUEUE, 16'h0003);
    tick(); seg_ovr_en <= 1; seg_ovr_sel <= cfiaf_pkg::seg_extra;
    mem_form(cfiaf_pkg::ref_data, 16'h0005, 20'h00005);
    mem_form(cfiaf_pkg::ref_fetch, 16'h0000, 20'h00004);
    tick(); seg_ovr_en <= 0;
    alu_run(cfiaf_pkg::op_sub, 1, 16'h1234, 16'h1234,
            16'h0000, 16'hF044);
    alu_run(cfiaf_pkg::op_add, 0, 16'h007F, 16'h0001,
            16'h0080, 16'hF890);
    alu_run(cfiaf_pkg::op_add, 1, 16'hFF00, 16'h0203,
            16'h0103, 16'hF005);
    alu_run(cfiaf_pkg::op_rcl, 1, 16'h4000, 16'h0000,
            16'h8001, 16'hF804);
    reg_write(cfiaf_pkg::REG_STATUS, 16'h0400);
    str_run(16'h0010, 16'h000E);
    reg_write(cfiaf_pkg::REG_STATUS, 16'h0000);
    str_run(16'h0010, 16'h0012);
    int_run(5'h01, cfiaf_pkg::cause_none);
    int_run(5'h04, cfiaf_pkg::cause_nmi);
    reg_write(cfiaf_pkg::REG_STATUS, 16'h0B2A);
    reg_read(cfiaf_pkg::REG_STATUS, 16'hFB00);
    int_run(5'h01, cfiaf_pkg::cause_mask);
    int_run(5'h02, cfiaf_pkg::cause_step);
    int_run(5'h08, cfiaf_pkg::cause_ovf);
    int_run(5'h14, cfiaf_pkg::cause_soft);
    repeat (3) tick();
    test_done();
  end
endmodule
